// file: flash_wake_dev.sv
// Device end: deep sleep release, signature output and power-up state
//
// Function
// RULE1: Deep sleep discards all but wake instruction
// RULE2: Wake instruction leaves deep sleep
// RULE3: Wake instruction outputs fixed 8-bit signature
// RULE4: Signature returned whenever no write cycle runs; the code also refuses it while any wake or settle countdown runs
// RULE5: Wake ignored during running write cycle
// RULE6: Master sends opcode then three dummy bytes
// RULE7: Signature shifted MSB first on falling edges
// RULE8: Signature repeats while clocking continues
// RULE9: Deselect after signature moves device to standby
// RULE10: Standby immediate, or after long wake delay
// RULE11: Master holds deselect for wake delay
// RULE12: Early deselect still wakes, short delay
// RULE13: Logic held reset below write inhibit
// RULE14: Write instructions ignored during write lockout
// RULE15: Master waits after supply before selecting
// RULE16: Master withholds writes until both delays
// RULE17: Power-up lands in standby, not sleep
// RULE18: Power-up clears write enable latch
// RULE19: Delivered array reads FFh, status 00h
// RULE20: Deep sleep only by command, after settling
// RULE21: Selection during wake delay is not accepted
`timescale 1ns/1ns
`default_nettype none
module flash_wake_dev #(
   parameter logic [7:0] SIGNATURE      = 8'h5a,  // Arbitrary value
   parameter int         LOCKOUT_CYC    = flash_wake_pkg::LOCKOUT_CYC,
   parameter int         SHORT_WAKE_CYC = flash_wake_pkg::SHORT_WAKE_CYC,
   parameter int         LONG_WAKE_CYC  = flash_wake_pkg::LONG_WAKE_CYC,
   parameter int         SETTLE_CYC     = flash_wake_pkg::SETTLE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   spi_link_if.dev         link,
   input  wire logic       busy_in,
   output logic            deep_sleep_q,
   output logic            standby_q,
   output logic            wel_q,
   output logic            lockout_q,
   output logic [7:0]      status_q
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int W = flash_wake_pkg::WAIT_W;

   // Link clock domain
   logic [5:0]                cnt_q;        // Rising edges seen in frame
   logic [6:0]                sh_q;         // Opcode shifter
   flash_wake_pkg::frame_cmd_e cmd_q;       // Command left at deselect
   logic                      sig_en_q;     // Signature output armed
   logic                      sig_done_q;   // One whole signature sent
   logic [3:0]                st_meta_q;    // First stage, state crossing
   logic [3:0]                st_q;         // Second stage, state crossing
   logic                      so_q;         // Output bit
   logic                      so_oe_n_q;    // Output enable, low drives
   logic [7:0]                opcode;       // Full opcode at eighth edge

   // System clock domain
   logic                      cs_meta_q;    // First stage, select sync
   logic                      cs_sync_q;    // Second stage, select sync
   logic                      cs_prev_q;    // Edge detect on synced select
   logic                      cs_rise;      // Frame just ended
   logic [W-1:0]              lock_cnt_q;   // Write lockout countdown
   logic [W-1:0]              wait_cnt_q;   // Wake or settle countdown
   logic                      wait_q;       // Countdown running
   logic                      wait_wake_q;  // Countdown ends a wake
   logic                      busy_prev_q;  // Edge detect on busy

   // ----------------------------------------------------------------
   // Link domain: state crossing
   // ----------------------------------------------------------------
   // Sleep, busy, lockout and not-accepted levels, two flops on the
   // link clock; the link clock only runs in frames, so the first
   // two edges of a frame settle them well before the opcode ends.
   always_ff @(posedge link.sck) begin
      st_meta_q <= {deep_sleep_q, busy_in, lockout_q, wait_q | ~rst_b};
      st_q      <= st_meta_q;
   end

   // ----------------------------------------------------------------
   // Link domain: bit counter
   // ----------------------------------------------------------------
   // Deselect clears the count; the frame's own signal ends it,
   // since no edge arrives after the last one.
   always_ff @(posedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         cnt_q <= 6'h00;
      end else if (cnt_q == flash_wake_pkg::SIG_LAST) begin
         cnt_q <= flash_wake_pkg::SIG_FIRST;  // RULE8
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // Opcode bits enter MSB first on rising edges
   always_ff @(posedge link.sck) begin
      sh_q <= {sh_q[5:0], link.si};  // RULE6
   end

   assign opcode = {sh_q, link.si};

   // ----------------------------------------------------------------
   // Link domain: decode
   // ----------------------------------------------------------------
   // Results stay put through deselect so the system side can read
   // them once the synced select has risen; a new frame clears them
   // on its first edge, so a short frame leaves nothing behind.
   always_ff @(posedge link.sck) begin
      if (cnt_q == 6'h00) begin
         cmd_q      <= flash_wake_pkg::CMD_NONE;
         sig_en_q   <= 1'b0;
         sig_done_q <= 1'b0;
      end else if (cnt_q == flash_wake_pkg::OP_LAST) begin
         // Not accepted during wake delay or reset
         if (st_q[0]) begin  // RULE21 RULE13
            cmd_q <= flash_wake_pkg::CMD_NONE;
         end else if (opcode == flash_wake_pkg::WAKE_AND_SIGNATURE_CMD) begin
            // Running write cycle: not decoded at all
            if (!st_q[2]) begin  // RULE5 RULE4
               cmd_q    <= flash_wake_pkg::CMD_WAKE;
               sig_en_q <= 1'b1;  // RULE3
            end
         end else if (st_q[3] || st_q[2]) begin
            // Deep sleep drops everything else; busy rejects too
            cmd_q <= flash_wake_pkg::CMD_NONE;  // RULE1
         end else if (opcode == flash_wake_pkg::DEEP_SLEEP_CMD) begin
            cmd_q <= flash_wake_pkg::CMD_SLEEP;  // RULE20
         end else if (opcode == flash_wake_pkg::WRITE_UNLOCK_CMD && !st_q[1]) begin
            cmd_q <= flash_wake_pkg::CMD_UNLOCK;  // RULE14
         end
         // Program, erase and status write carry no effect here
      end else if (cnt_q == flash_wake_pkg::SIG_LAST && sig_en_q) begin
         // Fortieth edge: master has latched the last signature bit
         sig_done_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Link domain: signature output
   // ----------------------------------------------------------------
   // Changes on the falling edge so the master samples mid-bit.
   // Bit index is the low count bits inverted: MSB comes first.
   always_ff @(negedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         so_q      <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else if (sig_en_q && cnt_q >= flash_wake_pkg::SIG_FIRST) begin
         so_q      <= SIGNATURE[~cnt_q[2:0]];  // RULE7 RULE8
         so_oe_n_q <= 1'b0;
      end
   end

   assign link.so      = so_q;
   assign link.so_oe_n = so_oe_n_q;

   // ----------------------------------------------------------------
   // System domain: select synchroniser
   // ----------------------------------------------------------------
   // Only the second stage feeds the edge detector
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         cs_meta_q <= link.cs_n;
         cs_sync_q <= cs_meta_q;
         cs_prev_q <= cs_sync_q;
      end
   end

   assign cs_rise = cs_sync_q & ~cs_prev_q;

   // ----------------------------------------------------------------
   // System domain: write lockout after power-on
   // ----------------------------------------------------------------
   // The power-on reset holds this at full count while low
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         lock_cnt_q <= W'(LOCKOUT_CYC);  // RULE14
         lockout_q  <= 1'b1;
      end else begin
         if (lock_cnt_q != '0) begin
            lock_cnt_q <= lock_cnt_q - W'(1);
         end
         lockout_q <= (lock_cnt_q > W'(1));
      end
   end

   // ----------------------------------------------------------------
   // System domain: sleep state and wake countdown
   // ----------------------------------------------------------------
   // Deselect after a frame acts on what the frame decoded. A wake
   // from standby is immediate; from deep sleep the countdown runs
   // and new selects are refused until it ends.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         deep_sleep_q <= 1'b0;  // RULE17
         wait_q       <= 1'b0;
         wait_wake_q  <= 1'b0;
         wait_cnt_q   <= '0;
      end else if (wait_q) begin
         if (wait_cnt_q == W'(1)) begin
            wait_q       <= 1'b0;
            // Wake ends in standby; settle ends in deep sleep
            deep_sleep_q <= ~wait_wake_q;  // RULE10 RULE20
         end
         wait_cnt_q <= wait_cnt_q - W'(1);  // RULE21
      end else if (cs_rise) begin
         unique case (cmd_q)
            flash_wake_pkg::CMD_WAKE: begin
               if (deep_sleep_q) begin
                  // Full signature seen: long delay, else short
                  wait_q      <= 1'b1;  // RULE2 RULE9
                  wait_wake_q <= 1'b1;
                  wait_cnt_q  <= sig_done_q ? W'(LONG_WAKE_CYC)
                                            : W'(SHORT_WAKE_CYC);  // RULE10 RULE12
               end
            end
            flash_wake_pkg::CMD_SLEEP: begin
               // Settle before the low-power state is taken
               wait_q      <= 1'b1;  // RULE20
               wait_wake_q <= 1'b0;
               wait_cnt_q  <= W'(SETTLE_CYC);
            end
            flash_wake_pkg::CMD_NONE, flash_wake_pkg::CMD_UNLOCK: begin
               wait_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // System domain: write enable latch
   // ----------------------------------------------------------------
   // A write cycle ending drops the latch; a deselect that sets it
   // in the same cycle wins, so the new unlock is not lost.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wel_q       <= 1'b0;  // RULE18
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= busy_in;
         if (cs_rise && cmd_q == flash_wake_pkg::CMD_UNLOCK) begin
            wel_q <= 1'b1;  // RULE14
         end else if (busy_prev_q && !busy_in) begin
            wel_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // System domain: visible state
   // ----------------------------------------------------------------
   // Standby means deselected, awake, idle and past any countdown
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         standby_q <= 1'b0;
         status_q  <= flash_wake_pkg::STATUS_DELIVERED;  // RULE19
      end else begin
         standby_q <= cs_sync_q & ~deep_sleep_q & ~wait_q & ~busy_in;  // RULE9
         status_q  <= {6'h00, wel_q, busy_in};
      end
   end

endmodule
`default_nettype wire

// file: flash_wake_pkg.sv
// Shared constants and types for the flash wake and signature link
package flash_wake_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_NS              = 10;        // sys_clk period
   localparam int SHORT_WAKE_NS       = 3000;      // Short wake delay
   localparam int LONG_WAKE_NS        = 30000;     // Long wake delay
   localparam int SLEEP_SETTLE_NS     = 3000;      // Settling before deep sleep
   localparam int LOCKOUT_NS          = 10000000;  // Write lockout delay, longest
   localparam int SEL_AFTER_SUPPLY_NS = 10000;     // Select after supply delay
   // Least times round up to whole cycles
   localparam int SHORT_WAKE_CYC   = (SHORT_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LONG_WAKE_CYC    = (LONG_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_CYC       = (SLEEP_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOCKOUT_CYC      = (LOCKOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEL_SUPPLY_CYC   = (SEL_AFTER_SUPPLY_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAIT_W           = 24;        // Width of delay counters

   // ----------------------------------------------------------------
   // Frame layout, counted in rising link clock edges
   // ----------------------------------------------------------------
   localparam logic [5:0] OP_LAST   = 6'h07;    // Edge count at last opcode bit
   localparam logic [5:0] SIG_FIRST = 6'h20;    // Opcode plus three dummy bytes
   localparam logic [5:0] SIG_LAST  = 6'h27;    // Last bit of a signature byte
   localparam logic [5:0] DUMMY_BITS = 6'h18;   // Three dummy bytes

   // ----------------------------------------------------------------
   // Instruction codes and delivery values
   // ----------------------------------------------------------------
   localparam logic [7:0] WAKE_AND_SIGNATURE_CMD = 8'hc1;
   localparam logic [7:0] DEEP_SLEEP_CMD         = 8'hc2;
   localparam logic [7:0] WRITE_UNLOCK_CMD       = 8'hc3;
   localparam logic [7:0] PAGE_PROGRAM_CMD       = 8'hc4;
   localparam logic [7:0] SECTOR_ERASE_CMD       = 8'hc5;
   localparam logic [7:0] BULK_ERASE_CMD         = 8'hc6;
   localparam logic [7:0] STATUS_WRITE_CMD       = 8'hc7;
   localparam logic [7:0] ERASED_BYTE            = 8'hff; // Array as delivered
   localparam logic [7:0] STATUS_DELIVERED       = 8'h00; // Status as delivered

   // Command a frame leaves behind at deselect
   typedef enum logic [1:0] {
      CMD_NONE   = 2'b00,
      CMD_WAKE   = 2'b01,
      CMD_SLEEP  = 2'b10,
      CMD_UNLOCK = 2'b11
   } frame_cmd_e;

   // Master sequencer states
   typedef enum logic [1:0] {
      M_PWR   = 2'b00,
      M_IDLE  = 2'b01,
      M_SHIFT = 2'b10,
      M_HOLD  = 2'b11
   } master_state_e;

endpackage

// file: flash_wake_props.sv
// Link checker for the flash wake frame
`timescale 1ns/1ns
`default_nettype none
module flash_wake_props #(
   parameter logic [7:0] SIG = 8'h5a  // Arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic so_line
);
   logic [7:0] edges_q;  // Rising link edges this frame
   logic       sck_q;    // Link clock one sample ago
   // Edge count restarts at each deselect
   always_ff @(posedge sys_clk) begin
      sck_q <= sck;
      if (cs_n) begin
         edges_q <= 8'h00;
      end else if (sck && !sck_q) begin
         edges_q <= edges_q + 8'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_release_on_deselect: assert property (cs_n |-> so_oe_n)
      else $error("output driven while deselected");
   a_so_on_fall: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !sck)
      else $error("output changed off falling edge");
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("link clock runs outside frame");
   a_si_held_high: assert property (sck && sck_q |-> $stable(si))
      else $error("input moved while clock high");
   a_after_dummies: assert property (!so_oe_n |-> edges_q >= 8'h20)
      else $error("output before dummy bytes end");
   a_sig_bits: assert property (!so_oe_n && sck && !sck_q
      |-> so_line == SIG[3'd7 - 3'(edges_q - 8'h20)])
      else $error("signature bit wrong");
   // Select is unknown before the first edge, so only a known deselect is held to it
   a_quiet_reset: assert property (disable iff (1'b0) !rst_b && cs_n |-> so_oe_n)
      else $error("output driven in reset");
   a_frame_mode: assert property ($fell(cs_n) |-> !sck)
      else $error("frame opened with clock high");
   cover property ($fell(so_oe_n));
   cover property ($rose(cs_n) && edges_q == 8'h08);
   cover property (edges_q == 8'h38);
endmodule
`default_nettype wire

// file: spi_link_if.sv
// Serial link between the bus master and the flash wake logic
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
   logic cs_n;     // Chip select, active low
   logic sck;      // Serial clock from the master
   logic si;       // Serial data into the device
   logic so;       // Serial data out of the device
   logic so_oe_n;  // Output enable, low while device drives
   logic so_line;  // Resolved line, pulled high when released

   // Pull-up stands in for the undriven line
   assign so_line = so_oe_n ? 1'b1 : so;

   modport dev  (input cs_n, input sck, input si, output so, output so_oe_n);
   modport host (output cs_n, output sck, output si, input so_line);
endinterface
`default_nettype wire

// file: spi_wake_master.sv
// Master end: sequences frames on the link and honours device delays
`timescale 1ns/1ns
`default_nettype none
module spi_wake_master #(
   parameter int HALF           = 4,  // sys_clk cycles per half link clock
   parameter int SEL_SUPPLY_CYC = flash_wake_pkg::SEL_SUPPLY_CYC,
   parameter int LOCKOUT_CYC    = flash_wake_pkg::LOCKOUT_CYC,
   parameter int SHORT_WAKE_CYC = flash_wake_pkg::SHORT_WAKE_CYC,
   parameter int LONG_WAKE_CYC  = flash_wake_pkg::LONG_WAKE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   spi_link_if.host        link,
   input  wire logic       start,
   input  wire logic [7:0] opcode,
   input  wire logic [1:0] rd_bytes,
   output logic            ready_q,
   output logic            done_q,
   output logic            refused_q,
   output logic [7:0]      sig_q
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int W = flash_wake_pkg::WAIT_W;

   flash_wake_pkg::master_state_e st_q;  // Sequencer state
   logic [W-1:0] cnt_q;       // Power-up or hold countdown
   logic [W-1:0] wr_cnt_q;    // Write withhold countdown
   logic [7:0]   div_q;       // Half period divider
   logic         sck_q;       // Link clock out
   logic         cs_n_q;      // Select out
   logic         si_q;        // Data out
   logic [7:0]   sh_q;        // Outgoing bits
   logic [7:0]   in_q;        // Incoming bits
   logic [5:0]   left_q;      // Bits still to send
   logic         wake_q;      // Frame is a wake instruction
   logic         long_q;      // Wake frame reads a signature
   logic         so_meta_q;   // First stage, data in sync
   logic         so_sync_q;   // Second stage, data in sync
   logic         is_write;    // Opcode needs the lockout over

   assign link.sck  = sck_q;
   assign link.cs_n = cs_n_q;
   assign link.si   = si_q;

   assign is_write = opcode == flash_wake_pkg::WRITE_UNLOCK_CMD ||
                     opcode == flash_wake_pkg::PAGE_PROGRAM_CMD ||
                     opcode == flash_wake_pkg::SECTOR_ERASE_CMD ||
                     opcode == flash_wake_pkg::BULK_ERASE_CMD ||
                     opcode == flash_wake_pkg::STATUS_WRITE_CMD;

   // ----------------------------------------------------------------
   // Data in synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      so_meta_q <= link.so_line;
      so_sync_q <= so_meta_q;
   end

   // ----------------------------------------------------------------
   // Write withhold countdown
   // ----------------------------------------------------------------
   // Longest lockout covers the select delay too
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_cnt_q <= W'(LOCKOUT_CYC);  // RULE16
      end else if (wr_cnt_q != '0) begin
         wr_cnt_q <= wr_cnt_q - W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Mode 0: data changes while the clock is low, sampled on rise.
   // HALF must be at least 3 so the synced data has settled.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q      <= flash_wake_pkg::M_PWR;
         cnt_q     <= W'(SEL_SUPPLY_CYC);  // RULE15
         div_q     <= 8'h00;
         sck_q     <= 1'b0;
         cs_n_q    <= 1'b1;
         si_q      <= 1'b0;
         sh_q      <= 8'h00;
         in_q      <= 8'h00;
         left_q    <= 6'h00;
         wake_q    <= 1'b0;
         long_q    <= 1'b0;
         ready_q   <= 1'b0;
         done_q    <= 1'b0;
         refused_q <= 1'b0;
         sig_q     <= 8'h00;
      end else begin
         done_q    <= 1'b0;
         refused_q <= 1'b0;
         unique case (st_q)
            flash_wake_pkg::M_PWR: begin
               // No select before the supply has settled
               if (cnt_q == '0) begin
                  st_q    <= flash_wake_pkg::M_IDLE;  // RULE15
                  ready_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - W'(1);
               end
            end
            flash_wake_pkg::M_IDLE: begin
               if (start && is_write && wr_cnt_q != '0) begin
                  refused_q <= 1'b1;  // RULE16
               end else if (start) begin
                  st_q    <= flash_wake_pkg::M_SHIFT;
                  ready_q <= 1'b0;
                  cs_n_q  <= 1'b0;  // RULE6
                  si_q    <= opcode[7];
                  sh_q    <= {opcode[6:0], 1'b0};
                  div_q   <= 8'h00;
                  wake_q  <= opcode == flash_wake_pkg::WAKE_AND_SIGNATURE_CMD;
                  long_q  <= rd_bytes != 2'b00;
                  left_q  <= (rd_bytes == 2'b00) ? 6'h08 :
                             6'h08 + flash_wake_pkg::DUMMY_BITS + {1'b0, rd_bytes, 3'b000};
               end
            end
            flash_wake_pkg::M_SHIFT: begin
               if (div_q == 8'(HALF - 1)) begin
                  div_q <= 8'h00;
                  if (!sck_q) begin
                     sck_q  <= 1'b1;
                     in_q   <= {in_q[6:0], so_sync_q};
                     left_q <= left_q - 6'h01;
                  end else if (left_q == 6'h00) begin
                     // Last bit taken: deselect and start the hold
                     sck_q  <= 1'b0;
                     cs_n_q <= 1'b1;  // RULE9
                     sig_q  <= in_q;
                     st_q   <= flash_wake_pkg::M_HOLD;
                     cnt_q  <= !wake_q ? W'(1) :
                               long_q ? W'(LONG_WAKE_CYC) : W'(SHORT_WAKE_CYC);  // RULE11
                  end else begin
                     sck_q <= 1'b0;
                     si_q  <= sh_q[7];
                     sh_q  <= {sh_q[6:0], 1'b0};
                  end
               end else begin
                  div_q <= div_q + 8'h01;
               end
            end
            flash_wake_pkg::M_HOLD: begin
               // Select stays high through the wake delay
               if (cnt_q <= W'(1)) begin
                  st_q    <= flash_wake_pkg::M_IDLE;
                  ready_q <= 1'b1;
                  done_q  <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - W'(1);
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench joining master and device ends
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic sys_clk = 1'b0, rst_b = 1'b0, busy_in = 1'b0, start = 1'b0, ref_seen;
   logic [7:0] opcode = 8'h00;
   logic [1:0] rd_bytes = 2'b00;
   logic ready_q, done_q, refused_q, deep_sleep_q, standby_q, wel_q, lockout_q;
   logic [7:0] sig_q, status_q;
   int mismatches = 0, compares = 0, cyc = 0;
   spi_link_if lk();
   // Lockout shortened alike on both ends; wake and settle delays keep real values
   flash_wake_dev #(.LOCKOUT_CYC(200)) i_flash_wake_dev (
      .sys_clk(sys_clk), .rst_b(rst_b), .link(lk),
      .busy_in(busy_in), .deep_sleep_q(deep_sleep_q), .standby_q(standby_q),
      .wel_q(wel_q), .lockout_q(lockout_q), .status_q(status_q));
   spi_wake_master #(.SEL_SUPPLY_CYC(20), .LOCKOUT_CYC(200)) i_spi_wake_master (
      .sys_clk(sys_clk), .rst_b(rst_b), .link(lk),
      .start(start), .opcode(opcode), .rd_bytes(rd_bytes), .ready_q(ready_q),
      .done_q(done_q), .refused_q(refused_q), .sig_q(sig_q));
   flash_wake_props i_flash_wake_props (.sys_clk(sys_clk), .rst_b(rst_b), .cs_n(lk.cs_n),
      .sck(lk.sck), .si(lk.si), .so(lk.so), .so_oe_n(lk.so_oe_n), .so_line(lk.so_line));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Hang guard: whole run is about 14700 cycles, four long wake holds
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One frame through the master, bounded waits on its handshake
   task automatic xfer(input logic [7:0] op, input logic [1:0] n);
      int k;
      k = 0;
      while (ready_q !== 1'b1 && k < 3000) begin tick(1); k++; end
      start = 1'b1; opcode = op; rd_bytes = n;
      tick(1);
      start = 1'b0; ref_seen = 1'b0;
      while (done_q !== 1'b1 && !ref_seen && k < 6000) begin
         ref_seen = (refused_q === 1'b1);
         tick(1);
         k++;
      end
      if (k >= 6000) chk("handshake", 8'h00, 8'h01);
   endtask
   initial begin
      tick(12);
      rst_b = 1'b1;
      chk("sleep", deep_sleep_q, 8'h00);
      chk("wel", wel_q, 8'h00);
      chk("status", status_q, 8'h00);
      chk("lockout", lockout_q, 8'h01);
      xfer(8'hc3, 2'd0);
      chk("refused", ref_seen, 8'h01);
      chk("wel", wel_q, 8'h00);
      xfer(8'hc1, 2'd1);
      chk("sig", sig_q, 8'h5a);
      tick(4);
      chk("standby", standby_q, 8'h01);
      xfer(8'hc1, 2'd3);
      chk("sig", sig_q, 8'h5a);
      chk("lockout", lockout_q, 8'h00);
      // Settle countdown starts three cycles after deselect
      xfer(8'hc2, 2'd0);
      tick(310);
      chk("sleep", deep_sleep_q, 8'h01);
      // Deselect reaches the device's latch through a two-flop sync
      xfer(8'hc3, 2'd0);
      tick(5);
      chk("wel", wel_q, 8'h00);
      // Master hold ends just before the device's own countdown
      xfer(8'hc1, 2'd1);
      chk("sig", sig_q, 8'h5a);
      chk("sleep", deep_sleep_q, 8'h01);
      tick(5);
      chk("sleep", deep_sleep_q, 8'h00);
      chk("standby", standby_q, 8'h01);
      xfer(8'hc3, 2'd0);
      tick(5);
      chk("wel", wel_q, 8'h01);
      busy_in = 1'b1;
      xfer(8'hc1, 2'd1);
      chk("sig", sig_q, 8'hff);
      busy_in = 1'b0;
      xfer(8'hc2, 2'd0);
      tick(310);
      // Opcode only: short delay, so the sleep ends well before a long one
      xfer(8'hc1, 2'd0);
      chk("sleep", deep_sleep_q, 8'h01);
      tick(5);
      chk("sleep", deep_sleep_q, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
